//--- design/sdpci_pkg.sv
// Shared constants, command codes and carrier types for the SDRAM pin interface
package sdpci_pkg;

  // Widths of the pin groups
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int DATA_W = 32;
  localparam int LANES = 4;

  // Mode word field positions
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;

  // Address bit that selects all banks during precharge
  localparam int PRE_ALL_BIT = 10;

  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // CAS latency code for the shorter pipeline
  localparam logic [2:0] CL_2 = 3'h2;

  // Mode word after reset (power-up content is undefined on the part)
  localparam logic [ROW_W-1:0] MODE_RST = 12'h030;

  // Column wrap masks per burst length
  localparam logic [COL_W-1:0] WRAP_1 = 8'h00;
  localparam logic [COL_W-1:0] WRAP_2 = 8'h01;
  localparam logic [COL_W-1:0] WRAP_4 = 8'h03;
  localparam logic [COL_W-1:0] WRAP_8 = 8'h07;
  localparam logic [COL_W-1:0] WRAP_FULL = 8'hFF;

  // Command codes as {row strobe, column strobe, write strobe}
  typedef enum logic [2:0] {
    SDPCI_MRS = 3'h0,
    SDPCI_REF = 3'h1,
    SDPCI_PRE = 3'h2,
    SDPCI_ACT = 3'h3,
    SDPCI_WR  = 3'h4,
    SDPCI_RD  = 3'h5,
    SDPCI_BST = 3'h6,
    SDPCI_NOP = 3'h7
  } sdpci_cmd_t;

  // Clock-enable power states, Gray coded
  typedef enum logic [1:0] {
    SDPCI_RUN  = 2'h0,
    SDPCI_SUSP = 2'h1,
    SDPCI_PDN  = 2'h3,
    SDPCI_SREF = 2'h2
  } sdpci_pwr_t;

  // Command strobe pins
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
  } sdpci_strobes_t;

  // Decoded command handed to the core
  typedef struct packed {
    sdpci_cmd_t code;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
    logic all_banks;
  } sdpci_cmd_info_t;

  // One write word for the array
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] be;
  } sdpci_wr_word_t;

endpackage

//--- design/sdpci_word_buf.sv
// Two-entry buffer for write words with valid and ready on both sides
`timescale 1ns/1ns
module sdpci_word_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  input sdpci_pkg::sdpci_wr_word_t in_word,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output sdpci_pkg::sdpci_wr_word_t out_word,
  input wire logic out_ready
);

  // Whole buffer state: head entry drives the output, tail catches spill
  typedef struct packed {
    logic h_v;
    sdpci_pkg::sdpci_wr_word_t h;
    logic t_v;
    sdpci_pkg::sdpci_wr_word_t t;
  } sdpci_buf_st_t;

  sdpci_buf_st_t st_r; // Registered state
  sdpci_buf_st_t st_nxt; // Next state

  // Ready while the tail slot is free, so a word never gets overwritten
  assign in_ready = !st_r.t_v;
  assign out_valid = st_r.h_v;
  assign out_word = st_r.h;

  // Pop first, then place an accepted word in the first free slot
  always_comb begin
    st_nxt = st_r;
    if (st_r.h_v && out_ready) begin
      st_nxt.h_v = st_r.t_v;
      st_nxt.h = st_r.t;
      st_nxt.t_v = 1'b0;
    end
    if (in_valid && !st_r.t_v) begin
      if (!st_nxt.h_v) begin
        st_nxt.h_v = 1'b1;
        st_nxt.h = in_word;
      end else begin
        st_nxt.t_v = 1'b1;
        st_nxt.t = in_word;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

//--- design/sdpci_pin_if.sv
// Pin-level command interface of a four-bank 32-bit synchronous DRAM
`timescale 1ns/1ns
module sdpci_pin_if (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command and address pins
  input wire logic clock_enable,
  input sdpci_pkg::sdpci_strobes_t strobes,
  input wire logic [11:0] addr,
  input wire logic [1:0] bank_select,
  input wire logic [3:0] byte_mask,
  // Data pins, split into input, output and per-lane enable
  input wire logic [31:0] data_lines_in,
  output logic [31:0] data_lines_out,
  output logic [3:0] data_lines_oe,
  // Decoded commands and status toward the array core
  output logic cmd_valid,
  output sdpci_pkg::sdpci_cmd_info_t cmd_info,
  output logic [11:0] mode_word,
  output sdpci_pkg::sdpci_pwr_t pwr_state,
  // Read port toward the array, data returned in the request cycle
  output logic rd_req,
  output logic [1:0] rd_bank,
  output logic [7:0] rd_col,
  input wire logic [31:0] rd_data,
  // Write stream toward the array
  output logic wr_valid,
  output sdpci_pkg::sdpci_wr_word_t wr_word,
  input wire logic wr_ready,
  output logic wr_overflow
);

  // Whole state of the interface
  typedef struct packed {
    sdpci_pkg::sdpci_pwr_t pwr;
    logic [11:0] mode;
    logic bst_on;
    logic bst_wr;
    logic [1:0] bst_bank;
    logic [7:0] bst_col;
    logic [7:0] bst_idx;
    logic [7:0] bst_wrap;
    logic cmd_v;
    sdpci_pkg::sdpci_cmd_info_t cmd;
    logic rd_v;
    logic [1:0] rd_bank;
    logic [7:0] rd_col;
    logic cap_v;
    logic [31:0] cap_d;
    logic [3:0] mask_d;
    logic [31:0] dout;
    logic [3:0] doe;
    logic ovf;
  } sdpci_core_st_t;

  sdpci_core_st_t st_r; // Registered state
  sdpci_core_st_t st_nxt; // Next state
  logic push_v; // Write word offered to the buffer
  sdpci_pkg::sdpci_wr_word_t push_w; // Word offered to the buffer
  logic push_rdy; // Buffer can take a word

  // Column of beat idx inside a burst: wraps inside the burst block
  function automatic logic [7:0] col_at(input logic [7:0] start,
                                        input logic [7:0] idx,
                                        input logic [7:0] wrap,
                                        input logic ilv);
    logic [7:0] low;
    low = ilv ? (start ^ idx) : 8'(start + idx);
    col_at = (start & ~wrap) | (low & wrap);
  endfunction

  // Wrap mask for a burst length code, single beat for unknown codes
  function automatic logic [7:0] wrap_of(input logic [2:0] code);
    unique case (code)
      sdpci_pkg::BL_2: wrap_of = sdpci_pkg::WRAP_2;
      sdpci_pkg::BL_4: wrap_of = sdpci_pkg::WRAP_4;
      sdpci_pkg::BL_8: wrap_of = sdpci_pkg::WRAP_8;
      sdpci_pkg::BL_FULL: wrap_of = sdpci_pkg::WRAP_FULL;
      default: wrap_of = sdpci_pkg::WRAP_1;
    endcase
  endfunction

  // Next-state logic; pins are read here only, so sampling is at the edge
  always_comb begin : next_state
    logic [2:0] code;
    logic [7:0] wrap;
    logic ilv;
    logic full;
    logic sel;
    logic [7:0] col;
    code = {strobes.row_strobe_n, strobes.column_strobe_n,
            strobes.write_strobe_n};
    sel = !strobes.chip_select_n;
    ilv = st_r.mode[sdpci_pkg::MODE_BT_BIT];
    full = (st_r.bst_wrap == sdpci_pkg::WRAP_FULL);
    wrap = '0;
    col = '0;
    st_nxt = st_r;
    st_nxt.cmd_v = 1'b0;
    st_nxt.rd_v = 1'b0;
    push_v = 1'b0;
    push_w = '0;
    unique case (st_r.pwr)
      // Normal running: decode, advance bursts, move read data
      sdpci_pkg::SDPCI_RUN: begin
        // Continue a burst already in progress
        if (st_r.bst_on) begin
          col = col_at(st_r.bst_col, st_r.bst_idx, st_r.bst_wrap, ilv);
          if (st_r.bst_wr) begin
            push_v = (byte_mask != 4'hF);
            push_w = '{bank: st_r.bst_bank, col: col, data: data_lines_in,
                       be: ~byte_mask};
          end else begin
            st_nxt.rd_v = 1'b1;
            st_nxt.rd_bank = st_r.bst_bank;
            st_nxt.rd_col = col;
          end
          st_nxt.bst_idx = st_r.bst_idx + 8'h01;
          if (!full && st_r.bst_idx == st_r.bst_wrap) begin
            st_nxt.bst_on = 1'b0;
          end
        end
        // A selected command; deselect leaves the burst running
        if (sel && code != sdpci_pkg::SDPCI_NOP) begin
          st_nxt.cmd_v = 1'b1;
          st_nxt.cmd = '{code: sdpci_pkg::sdpci_cmd_t'(code),
                         bank: bank_select, addr: addr,
                         all_banks: 1'b0};
          unique case (code)
            // Mode word loads from the address pins
            sdpci_pkg::SDPCI_MRS: begin
              st_nxt.mode = addr;
            end
            // Row address of the activate travels in the command
            sdpci_pkg::SDPCI_ACT: begin
              st_nxt.cmd.addr = addr;
            end
            // Precharge: one bank or all, and it ends a matching burst
            sdpci_pkg::SDPCI_PRE: begin
              st_nxt.cmd.all_banks = addr[sdpci_pkg::PRE_ALL_BIT];
              if (addr[sdpci_pkg::PRE_ALL_BIT] ||
                  bank_select == st_r.bst_bank) begin
                st_nxt.bst_on = 1'b0;
              end
            end
            // Read or write: restart the burst at the new column
            sdpci_pkg::SDPCI_RD, sdpci_pkg::SDPCI_WR: begin
              st_nxt.cmd.addr = {4'h0, addr[7:0]};
              wrap = wrap_of(st_r.mode[sdpci_pkg::MODE_BL_LSB +: 3]);
              if (code == sdpci_pkg::SDPCI_WR &&
                  st_r.mode[sdpci_pkg::MODE_WB_BIT]) begin
                wrap = sdpci_pkg::WRAP_1;
              end
              st_nxt.bst_wr = (code == sdpci_pkg::SDPCI_WR);
              st_nxt.bst_bank = bank_select;
              st_nxt.bst_col = addr[7:0];
              st_nxt.bst_wrap = wrap;
              st_nxt.bst_idx = 8'h01;
              st_nxt.bst_on = (wrap != sdpci_pkg::WRAP_1);
              // A stream beat issued above belongs to the old burst
              push_v = 1'b0;
              st_nxt.rd_v = 1'b0;
              if (code == sdpci_pkg::SDPCI_WR) begin
                push_v = (byte_mask != 4'hF);
                push_w = '{bank: bank_select, col: addr[7:0],
                           data: data_lines_in, be: ~byte_mask};
              end else begin
                st_nxt.rd_v = 1'b1;
                st_nxt.rd_bank = bank_select;
                st_nxt.rd_col = addr[7:0];
              end
            end
            // Burst stop: only a full-page burst stops, data drains
            sdpci_pkg::SDPCI_BST: begin
              if (full) begin
                st_nxt.bst_on = 1'b0;
                st_nxt.rd_v = 1'b0;
                push_v = 1'b0;
              end
            end
            // Refresh and anything else pass through as decoded
            default: begin
              st_nxt.cmd.addr = addr;
            end
          endcase
        end
        // Read data pipeline: capture, then present at the latency
        st_nxt.cap_v = st_r.rd_v;
        st_nxt.cap_d = rd_data;
        if (st_r.mode[sdpci_pkg::MODE_CL_LSB +: 3] == sdpci_pkg::CL_2) begin
          st_nxt.dout = rd_data;
          st_nxt.doe = {4{st_r.rd_v}} & ~st_r.mask_d;
        end else begin
          st_nxt.dout = st_r.cap_d;
          st_nxt.doe = {4{st_r.cap_v}} & ~st_r.mask_d;
        end
        // Mask sampled now acts on the output loaded one edge later
        st_nxt.mask_d = byte_mask;
        // Clock enable low: pick the low-power state from the situation
        if (!clock_enable) begin
          if (sel && code == sdpci_pkg::SDPCI_REF) begin
            st_nxt.pwr = sdpci_pkg::SDPCI_SREF;
            st_nxt.bst_on = 1'b0;
          end else if (st_r.bst_on || st_r.rd_v || st_r.cap_v) begin
            st_nxt.pwr = sdpci_pkg::SDPCI_SUSP;
          end else begin
            st_nxt.pwr = sdpci_pkg::SDPCI_PDN;
          end
        end
      end
      // Suspended or powered down: state holds, with command valid and read request cleared, until enable returns
      sdpci_pkg::SDPCI_SUSP, sdpci_pkg::SDPCI_PDN,
      sdpci_pkg::SDPCI_SREF: begin
        if (clock_enable) begin
          st_nxt.pwr = sdpci_pkg::SDPCI_RUN;
        end
      end
    endcase
    // Overflow is sticky once a word finds the buffer full
    if (push_v && !push_rdy) begin
      st_nxt.ovf = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.pwr <= sdpci_pkg::SDPCI_RUN;
      st_r.mode <= sdpci_pkg::MODE_RST;
      st_r.cmd.code <= sdpci_pkg::SDPCI_NOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Write words wait here so a stall by the array loses none of the first two; a third sets the overflow flag
  sdpci_word_buf u_wr_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_v),
    .in_word(push_w),
    .in_ready(push_rdy),
    .out_valid(wr_valid),
    .out_word(wr_word),
    .out_ready(wr_ready)
  );

  // Outputs straight from the state register
  assign data_lines_out = st_r.dout;
  assign data_lines_oe = st_r.doe;
  assign cmd_valid = st_r.cmd_v;
  assign cmd_info = st_r.cmd;
  assign mode_word = st_r.mode;
  assign pwr_state = st_r.pwr;
  assign rd_req = st_r.rd_v;
  assign rd_bank = st_r.rd_bank;
  assign rd_col = st_r.rd_col;
  assign wr_overflow = st_r.ovf;

endmodule

//--- tb/sdpci_pin_if_chk.sv
// Assertion checker for the SDRAM pin command interface
`timescale 1ns/1ns
module sdpci_pin_if_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic clock_enable,
  input sdpci_pkg::sdpci_strobes_t strobes,
  input wire logic [11:0] addr,
  input wire logic [1:0] bank_select,
  input wire logic [3:0] byte_mask,
  input wire logic [31:0] data_lines_in,
  input wire logic [3:0] data_lines_oe,
  // Core side
  input wire logic cmd_valid,
  input sdpci_pkg::sdpci_cmd_info_t cmd_info,
  input wire logic [11:0] mode_word,
  input sdpci_pkg::sdpci_pwr_t pwr_state,
  input wire logic rd_req,
  input wire logic [1:0] rd_bank,
  input wire logic [7:0] rd_col,
  input wire logic wr_valid,
  input sdpci_pkg::sdpci_wr_word_t wr_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take, run, a10;
  logic [2:0] op;
  // Strobe code and command acceptance at this edge
  assign op = strobes[2:0];
  assign run = pwr_state == sdpci_pkg::SDPCI_RUN;
  assign take = run && !strobes.chip_select_n && op != 3'h7;
  assign a10 = addr[sdpci_pkg::PRE_ALL_BIT];
  cs_ignore_a: assert property (strobes.chip_select_n |=> !cmd_valid)
    else $error("deselected command was taken");
  cmd_take_a: assert property (take |=> cmd_valid &&
    cmd_info.code == $past(op)) else $error("command code lost");
  low_power_a: assert property (!run |=> !cmd_valid)
    else $error("command taken while clock off");
  pwr_enter_a: assert property (run && !clock_enable |=> !run)
    else $error("clock enable low ignored");
  act_addr_a: assert property (take && op == 3'h3 |=>
    cmd_info.bank == $past(bank_select) && cmd_info.addr == $past(addr))
    else $error("activate bank or row wrong");
  pre_all_a: assert property (take && op == 3'h2 |=>
    cmd_info.all_banks == $past(a10)) else $error("precharge-all wrong");
  mode_set_a: assert property (take && op == 3'h0 |=>
    mode_word == $past(addr)) else $error("mode word not loaded");
  rd_start_a: assert property (take && op == 3'h5 |=> rd_req &&
    {4'h0, rd_col} == ($past(addr) & 12'h0FF) &&
    rd_bank == $past(bank_select)) else $error("read start wrong");
  wr_first_a: assert property (take && op == 3'h4 && !wr_valid &&
    byte_mask != 4'hF |=> wr_valid &&
    wr_word.data == $past(data_lines_in) &&
    wr_word.be == ~$past(byte_mask)) else $error("first write word wrong");
  rd_mask_a: assert property (byte_mask != 4'h0 && run && clock_enable
    |-> ##2 (data_lines_oe & $past(byte_mask, 2)) == 4'h0)
    else $error("masked lane still driven");
endmodule

//--- tb/sdpci_array_model.sv
// Array-side partner: read words by address, write sink that can stall
`timescale 1ns/1ns
module sdpci_array_model (
  // Read port
  input wire logic rd_req,
  input wire logic [1:0] rd_bank,
  input wire logic [7:0] rd_col,
  output logic [31:0] rd_data,
  // Write port
  input wire logic hold,
  output logic wr_ready
);
  logic [31:0] word;
  // Word depends on bank and column so misrouting shows
  assign word = {rd_bank, 6'h2A, ~rd_col, 8'hC3, rd_col};
  // Outside a request show garbage, never the last word
  assign rd_data = rd_req ? word : ~word;
  // Stall on request of the bench
  assign wr_ready = !hold;
endmodule

//--- tb/sdram_pin_command_interface_bench.sv
// Bench for the SDRAM pin command interface
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sdram_pin_command_interface_bench;
  logic clk = 0, nrst = 0, cke = 1, hold = 0;
  sdpci_pkg::sdpci_strobes_t st = 4'hF;
  logic [11:0] ad = 12'h000, mw;
  logic [1:0] bs = 2'h0, rb;
  logic [3:0] bm = 4'h0, oe;
  logic [31:0] drv = 32'h0, dout, din, rdd, oex;
  logic [7:0] rc;
  logic cv, rq, wv, wrdy, ovf;
  sdpci_pkg::sdpci_cmd_info_t ci;
  sdpci_pkg::sdpci_wr_word_t ww;
  sdpci_pkg::sdpci_pwr_t pw;
  int failures = 0, n_checks = 0;
  // Clock, 8 ns period
  always #4 clk = ~clk;
  // Wire level: device lanes where enabled, else bench value
  assign oex = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
  assign din = (dout & oex) | (drv & ~oex);
  sdpci_pin_if u_dut (.clk(clk), .nrst(nrst), .clock_enable(cke),
    .strobes(st), .addr(ad), .bank_select(bs), .byte_mask(bm),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe),
    .cmd_valid(cv), .cmd_info(ci), .mode_word(mw), .pwr_state(pw),
    .rd_req(rq), .rd_bank(rb), .rd_col(rc), .rd_data(rdd),
    .wr_valid(wv), .wr_word(ww), .wr_ready(wrdy), .wr_overflow(ovf));
  sdpci_array_model u_mem (.rd_req(rq), .rd_bank(rb), .rd_col(rc),
    .rd_data(rdd), .hold(hold), .wr_ready(wrdy));
  // Print counts and verdict, then stop
  task automatic results;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Present one command at an edge, return just after it
  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
    input logic [11:0] a, input logic n = 1'b0);
    @(negedge clk);
    st <= {n, c};
    bs <= b;
    ad <= a;
    @(posedge clk);
    #1;
  endtask
  // Every non-data command code except NOP, then activate, precharge and deselect
  task automatic t_cmds;
    for (int c = 0; c < 7; c++) begin
      if (c == 4 || c == 5) continue;
      cmd(3'(c), 2'h2, c == 0 ? 12'h030 : 12'hABC);
      `CHK(ci.code, 3'(c))
    end
    cmd(3'h3, 2'h2, 12'hABC);
    `CHK(ci.bank, 2'h2)
    `CHK(ci.addr, 12'hABC)
    cmd(3'h2, 2'h1, 12'h400);
    `CHK(ci.all_banks, 1'b1)
    cmd(3'h2, 2'h1, 12'h3FF);
    `CHK(ci.all_banks, 1'b0)
    cmd(3'h5, 2'h0, 12'h000, 1'b1);
    `CHK(cv, 1'b0)
    `CHK(rq, 1'b0)
  endtask
  // Burst of four at latency three, lane 2 masked on beat 1
  task automatic t_read;
    cmd(3'h0, 2'h0, 12'h032);
    `CHK(mw, 12'h032)
    @(negedge clk);
    st <= 4'h5;
    bs <= 2'h1;
    ad <= 12'h010;
    for (int j = 0; j < 7; j++) begin
      @(posedge clk);
      #1;
      `CHK(rq, 1'(j < 4))
      if (j < 4) `CHK({rb, rc}, 10'(10'h110 + j))
      if (j >= 2 && j < 6) `CHK(dout & oex, {2'h1, 6'h2A,
        ~8'(8'h0E + j), 8'hC3, 8'(8'h0E + j)} & oex)
      `CHK(oe, (j < 2 || j > 5) ? 4'h0 : (j == 3 ? 4'hB : 4'hF))
      @(negedge clk);
      st <= 4'h7;
      bm <= (j == 1) ? 4'h4 : 4'h0;
    end
  endtask
  // Stalled write burst: masked beat dropped, third word overflows
  task automatic t_write;
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      st <= (i == 0) ? 4'h4 : 4'h7;
      bs <= 2'h0;
      ad <= 12'h005;
      drv <= {4{8'(8'hA0 + i)}};
      bm <= 4'(16'h03F0 >> (4 * i));
    end
    @(negedge clk);
    st <= 4'h7;
    bm <= 4'h0;
    @(posedge clk);
    #1;
    `CHK({wv, ovf, ww.col, ww.be}, 14'h305F)
    `CHK(ww.data, 32'hA0A0A0A0)
    @(negedge clk);
    hold <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({wv, ww.col, ww.be}, 13'h107C)
    `CHK(ww.data, 32'hA2A2A2A2)
    @(posedge clk);
    #1;
    `CHK(wv, 1'b0)
  endtask
  // Power-down entry refuses commands, wake-up restores them
  task automatic t_cke;
    @(negedge clk);
    cke <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(pw, sdpci_pkg::SDPCI_PDN)
    cmd(3'h3, 2'h0, 12'h001);
    `CHK(cv, 1'b0)
    @(negedge clk);
    st <= 4'h7;
    cke <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(pw, sdpci_pkg::SDPCI_RUN)
    cmd(3'h3, 2'h3, 12'h123);
    `CHK({cv, ci.bank}, 3'h7)
  endtask
  // Second reset clears sticky overflow and sets the mode word back to 12'h030
  task automatic t_reset;
    @(negedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    nrst <= 1'b1;
    `CHK({ovf, mw}, 13'h0030)
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    `CHK({pw, mw}, 14'h0030)
    nrst <= 1'b1;
    st <= 4'h7;
    t_cmds();
    t_read();
    t_write();
    t_cke();
    t_reset();
    results();
  end
  // Watchdog well beyond the roughly fifty cycles expected
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule
bind sdpci_pin_if sdpci_pin_if_chk u_chk (.clk(clk), .nrst(nrst),
  .clock_enable(clock_enable), .strobes(strobes), .addr(addr),
  .bank_select(bank_select), .byte_mask(byte_mask),
  .data_lines_in(data_lines_in), .data_lines_oe(data_lines_oe),
  .cmd_valid(cmd_valid), .cmd_info(cmd_info), .mode_word(mode_word),
  .pwr_state(pwr_state), .rd_req(rd_req), .rd_bank(rd_bank),
  .rd_col(rd_col), .wr_valid(wr_valid), .wr_word(wr_word));
